//--- sdio_pin_pkg.sv
`default_nettype none
package sdio_pin_pkg;
    localparam int unsigned REF_CLK_HZ = 100_000_000;
    localparam int unsigned SLEEP_CLK_HZ = 32_768;
    // expected reference cycles per sleep period
    localparam int unsigned REF_PER_SLEEP_NOM = REF_CLK_HZ / SLEEP_CLK_HZ;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned SYNC_W = 9;
    localparam int unsigned PAD_CLK = 0;
    localparam int unsigned PAD_CMD = 1;
    localparam int unsigned PAD_DAT0 = 2;
    localparam int unsigned PAD_DAT1 = 3;
    localparam int unsigned PAD_DAT2 = 4;
    localparam int unsigned PAD_DAT3 = 5;
    localparam int unsigned PAD_PWRDN = 6;
    localparam int unsigned PAD_EXTRST = 7;
    localparam int unsigned PAD_SLEEP = 8;
    localparam int unsigned CIS_DEPTH = 16;
    localparam int unsigned CIS_AW = 4;
    localparam logic [7:0] CMD0_HEAD = 8'h40;
    localparam logic [5:0] CMD_HEAD_LAST = 6'h07;
    localparam logic [5:0] CMD_FRAME_LAST = 6'h2f;
    localparam logic [SYNC_W-1:0] SYNC_RST = 9'h000;
    typedef enum logic [1:0] {
        MODE_SD1 = 2'b00,
        MODE_SD4 = 2'b01,
        MODE_SPI = 2'b10
    } bus_mode_t;
    localparam bus_mode_t MODE_RST = MODE_SD1;
endpackage
`default_nettype wire

//--- pad_sync_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pad_sync_if;
    logic [sdio_pin_pkg::SYNC_W-1:0] raw;
    logic [sdio_pin_pkg::SYNC_W-1:0] lvl;
    logic [sdio_pin_pkg::SYNC_W-1:0] rise;
    logic [sdio_pin_pkg::SYNC_W-1:0] fall;
    modport sync (input raw, output lvl, output rise, output fall);
    modport user (output raw, input lvl, input rise, input fall);
endinterface
`default_nettype wire

//--- pad_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pad_sync (
    input wire logic ref_clk,
    input wire logic arst_n,
    pad_sync_if.sync pads
);
    typedef struct packed {
        logic [sdio_pin_pkg::SYNC_W-1:0] s1;
        logic [sdio_pin_pkg::SYNC_W-1:0] s2;
        logic [sdio_pin_pkg::SYNC_W-1:0] s3;
        logic [sdio_pin_pkg::SYNC_W-1:0] lvl;
        logic [sdio_pin_pkg::SYNC_W-1:0] rise;
        logic [sdio_pin_pkg::SYNC_W-1:0] fall;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    // a level is taken only once the second and third stages agree
    always_comb begin
        st_d = st_q;
        st_d.s1 = pads.raw;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < int'(sdio_pin_pkg::SYNC_W); i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.lvl[i] = st_q.s3[i];
            end
        end
        st_d.rise = st_d.lvl & ~st_q.lvl;
        st_d.fall = ~st_d.lvl & st_q.lvl;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pads.lvl = st_q.lvl;
    assign pads.rise = st_q.rise;
    assign pads.fall = st_q.fall;
endmodule
`default_nettype wire

//--- sdio_pin_mode_and_reset.sv
`timescale 1ns/1ns
`default_nettype none
module sdio_pin_mode_and_reset (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic card_clock_pad,
    input wire logic card_command_pad_i,
    output logic card_command_pad_o,
    output logic card_command_pad_oe_n,
    input wire logic card_data0_pad_i,
    output logic card_data0_pad_o,
    output logic card_data0_pad_oe_n,
    input wire logic card_data1_pad_i,
    output logic card_data1_pad_o,
    output logic card_data1_pad_oe_n,
    input wire logic card_data2_pad_i,
    output logic card_data2_pad_o,
    output logic card_data2_pad_oe_n,
    input wire logic card_data3_pad_i,
    output logic card_data3_pad_o,
    output logic card_data3_pad_oe_n,
    input wire logic power_down_reset_pin,
    input wire logic external_reset_pin,
    input wire logic sleep_clock_pin,
    input wire logic soft_reset,
    input wire logic core_cmd_o,
    input wire logic core_cmd_oe,
    input wire logic [3:0] core_dat_o,
    input wire logic [3:0] core_dat_oe,
    input wire logic read_wait_req,
    input wire logic width_set,
    input wire logic width_four,
    input wire logic fw_irq_set,
    input wire logic host_irq_clr,
    input wire logic cis_wr_en,
    input wire logic [sdio_pin_pkg::CIS_AW-1:0] cis_wr_addr,
    input wire logic [7:0] cis_wr_data,
    input wire logic [sdio_pin_pkg::CIS_AW-1:0] cis_rd_addr,
    output logic [7:0] cis_rd_data,
    output logic host_cmd_bit,
    output logic [3:0] host_dat_bits,
    output logic card_clk_rise,
    output logic [1:0] bus_mode,
    output logic core_rst_n,
    output logic boot_start,
    output logic irq_pending,
    output logic [sdio_pin_pkg::CNT_W-1:0] ref_per_sleep,
    output logic ref_count_valid,
    output logic sleep_tick
);
    typedef struct packed {
        sdio_pin_pkg::bus_mode_t mode;
        logic cmd0_seen;
        logic [5:0] bit_cnt;
        logic [7:0] cmd_sr;
        logic irq;
        logic in_reset;
        logic core_rst_n;
        logic boot_start;
        logic cmd_o;
        logic cmd_oe_n;
        logic [3:0] dat_o;
        logic [3:0] dat_oe_n;
        logic [sdio_pin_pkg::CNT_W-1:0] sleep_cnt;
        logic [sdio_pin_pkg::CNT_W-1:0] ref_per_sleep;
        logic sleep_seen;
        logic ref_count_valid;
        logic [7:0] cis_rd_data;
        logic [sdio_pin_pkg::CIS_DEPTH-1:0][7:0] cis;
    } top_state_t;

    top_state_t st_q;
    top_state_t st_d;
    logic in_reset;
    logic cs_low;
    logic cmd_bit;
    logic [7:0] cmd_head;

    pad_sync_if pads ();

    assign pads.raw = {sleep_clock_pin, external_reset_pin, power_down_reset_pin,
        card_data3_pad_i, card_data2_pad_i, card_data1_pad_i, card_data0_pad_i,
        card_command_pad_i, card_clock_pad};

    pad_sync u_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .pads(pads.sync)
    );

    assign in_reset = !pads.lvl[sdio_pin_pkg::PAD_PWRDN]
        || !pads.lvl[sdio_pin_pkg::PAD_EXTRST] || soft_reset;
    assign cs_low = !pads.lvl[sdio_pin_pkg::PAD_DAT3];
    assign cmd_bit = pads.lvl[sdio_pin_pkg::PAD_CMD];
    assign cmd_head = {st_q.cmd_sr[6:0], cmd_bit};

    always_comb begin
        st_d = st_q;
        st_d.in_reset = in_reset;
        st_d.core_rst_n = !in_reset;
        st_d.boot_start = st_q.in_reset && !in_reset;

        // device sets, host clears; set wins
        st_d.irq = (st_q.irq && !host_irq_clr) || fw_irq_set;

        if (pads.rise[sdio_pin_pkg::PAD_CLK] && !core_cmd_oe) begin
            if (st_q.bit_cnt == 6'h00) begin
                if (!cmd_bit) begin
                    st_d.bit_cnt = 6'h01;
                    st_d.cmd_sr = cmd_head;
                end
            end else begin
                st_d.cmd_sr = cmd_head;
                if (st_q.bit_cnt == sdio_pin_pkg::CMD_FRAME_LAST) begin
                    st_d.bit_cnt = 6'h00;
                end else begin
                    st_d.bit_cnt = st_q.bit_cnt + 6'h01;
                end
                if (st_q.bit_cnt == sdio_pin_pkg::CMD_HEAD_LAST
                    && cmd_head == sdio_pin_pkg::CMD0_HEAD) begin
                    if (!st_q.cmd0_seen) begin
                        st_d.cmd0_seen = 1'b1;
                        // select low at first reset picks SPI
                        st_d.mode = cs_low ? sdio_pin_pkg::MODE_SPI : sdio_pin_pkg::MODE_SD1;
                    end else if (st_q.mode != sdio_pin_pkg::MODE_SPI) begin
                        st_d.mode = sdio_pin_pkg::MODE_SD1;
                    end
                end
            end
        end
        // four lines only when host configures
        if (width_set && st_q.mode != sdio_pin_pkg::MODE_SPI) begin
            st_d.mode = width_four ? sdio_pin_pkg::MODE_SD4 : sdio_pin_pkg::MODE_SD1;
        end

        // pads released unless driven by core request, interrupt (data1) or read wait (data2)
        st_d.cmd_o = 1'b1;
        st_d.cmd_oe_n = 1'b1;
        st_d.dat_o = 4'hf;
        st_d.dat_oe_n = 4'hf;
        case (st_q.mode)
            sdio_pin_pkg::MODE_SD4: begin
                st_d.cmd_o = core_cmd_o;
                st_d.cmd_oe_n = !core_cmd_oe;
                st_d.dat_o = core_dat_o;
                st_d.dat_oe_n = ~core_dat_oe;
                if (read_wait_req && !core_dat_oe[2]) begin
                    st_d.dat_o[2] = 1'b0;
                    st_d.dat_oe_n[2] = 1'b0;
                end
                if (st_q.irq && !core_dat_oe[1]) begin
                    st_d.dat_o[1] = 1'b0;
                    st_d.dat_oe_n[1] = 1'b0;
                end
            end
            sdio_pin_pkg::MODE_SD1: begin
                st_d.cmd_o = core_cmd_o;
                st_d.cmd_oe_n = !core_cmd_oe;
                st_d.dat_o[0] = core_dat_o[0];
                st_d.dat_oe_n[0] = !core_dat_oe[0];
                if (st_q.irq) begin
                    st_d.dat_o[1] = 1'b0;
                    st_d.dat_oe_n[1] = 1'b0;
                end
                if (read_wait_req) begin
                    st_d.dat_o[2] = 1'b0;
                    st_d.dat_oe_n[2] = 1'b0;
                end
            end
            sdio_pin_pkg::MODE_SPI: begin
                // command in, data3 select, data2 released
                if (cs_low && core_dat_oe[0]) begin
                    st_d.dat_o[0] = core_dat_o[0];
                    st_d.dat_oe_n[0] = 1'b0;
                end
                if (st_q.irq) begin
                    st_d.dat_o[1] = 1'b0;
                    st_d.dat_oe_n[1] = 1'b0;
                end
            end
            default: begin
                st_d.mode = sdio_pin_pkg::MODE_RST;
            end
        endcase

        if (in_reset) begin
            st_d.mode = sdio_pin_pkg::MODE_RST;
            st_d.cmd0_seen = 1'b0;
            st_d.bit_cnt = 6'h00;
            st_d.irq = 1'b0;
            st_d.cmd_o = 1'b1;
            st_d.cmd_oe_n = 1'b1;
            st_d.dat_o = 4'hf;
            st_d.dat_oe_n = 4'hf;
        end

        // sleep clock runs through core reset
        if (pads.rise[sdio_pin_pkg::PAD_SLEEP]) begin
            st_d.sleep_cnt = {{(sdio_pin_pkg::CNT_W-1){1'b0}}, 1'b1};
            st_d.sleep_seen = 1'b1;
            if (st_q.sleep_seen) begin
                st_d.ref_per_sleep = st_q.sleep_cnt;
                st_d.ref_count_valid = 1'b1;
            end
        end else if (st_q.sleep_cnt != '1) begin
            st_d.sleep_cnt = st_q.sleep_cnt + sdio_pin_pkg::CNT_W'(1);
        end

        if (cis_wr_en) begin
            st_d.cis[cis_wr_addr] = cis_wr_data;
        end
        st_d.cis_rd_data = st_q.cis[cis_rd_addr];
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
            st_q.mode <= sdio_pin_pkg::MODE_RST;
            st_q.in_reset <= 1'b1;
            st_q.cmd_o <= 1'b1;
            st_q.cmd_oe_n <= 1'b1;
            st_q.dat_o <= 4'hf;
            st_q.dat_oe_n <= 4'hf;
        end else begin
            st_q <= st_d;
        end
    end

    assign card_command_pad_o = st_q.cmd_o;
    assign card_command_pad_oe_n = st_q.cmd_oe_n;
    assign card_data0_pad_o = st_q.dat_o[0];
    assign card_data0_pad_oe_n = st_q.dat_oe_n[0];
    assign card_data1_pad_o = st_q.dat_o[1];
    assign card_data1_pad_oe_n = st_q.dat_oe_n[1];
    assign card_data2_pad_o = st_q.dat_o[2];
    assign card_data2_pad_oe_n = st_q.dat_oe_n[2];
    assign card_data3_pad_o = st_q.dat_o[3];
    assign card_data3_pad_oe_n = st_q.dat_oe_n[3];
    assign cis_rd_data = st_q.cis_rd_data;
    assign host_cmd_bit = pads.lvl[sdio_pin_pkg::PAD_CMD];
    assign host_dat_bits = pads.lvl[sdio_pin_pkg::PAD_DAT3:sdio_pin_pkg::PAD_DAT0];
    assign card_clk_rise = pads.rise[sdio_pin_pkg::PAD_CLK];
    assign bus_mode = st_q.mode;
    assign core_rst_n = st_q.core_rst_n;
    assign boot_start = st_q.boot_start;
    assign irq_pending = st_q.irq;
    assign ref_per_sleep = st_q.ref_per_sleep;
    assign ref_count_valid = st_q.ref_count_valid;
    assign sleep_tick = pads.rise[sdio_pin_pkg::PAD_SLEEP];

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    a_spi_cmd_input: assert property (
        (st_q.mode == sdio_pin_pkg::MODE_SPI) |=> card_command_pad_oe_n)
        else $error("command pad driven in SPI mode");
    a_dat3_one_line: assert property (
        (st_q.mode != sdio_pin_pkg::MODE_SD4) |=> card_data3_pad_oe_n)
        else $error("data3 driven outside four-line mode");
    a_dat2_spi_reserved: assert property (
        (st_q.mode == sdio_pin_pkg::MODE_SPI) |=> card_data2_pad_oe_n)
        else $error("data2 driven in SPI mode");
    a_dat1_irq_drive: assert property (
        (st_q.mode != sdio_pin_pkg::MODE_SD4 && st_q.irq && !in_reset)
        |=> (!card_data1_pad_oe_n && !card_data1_pad_o))
        else $error("interrupt not shown on data1");
    a_dat0_spi_out: assert property (
        (st_q.mode == sdio_pin_pkg::MODE_SPI && cs_low && core_dat_oe[0] && !in_reset)
        |=> (!card_data0_pad_oe_n && card_data0_pad_o == $past(core_dat_o[0])))
        else $error("SPI data out not driven");
    a_irq_set_wins: assert property (
        (fw_irq_set && !in_reset) |=> irq_pending)
        else $error("interrupt set lost");
    a_reset_default: assert property (
        in_reset |=> (bus_mode == sdio_pin_pkg::MODE_RST && !core_rst_n && !irq_pending))
        else $error("reset did not restore default state");
    a_boot_on_rise: assert property (
        ($past(st_q.in_reset) && st_q.in_reset && !in_reset) |=> boot_start ##1 !boot_start)
        else $error("boot pulse wrong");
    a_spi_select: assert property (
        (st_q.bit_cnt == sdio_pin_pkg::CMD_HEAD_LAST && card_clk_rise && !core_cmd_oe
        && cmd_head == sdio_pin_pkg::CMD0_HEAD && !st_q.cmd0_seen && cs_low
        && !in_reset && !width_set)
        |=> bus_mode == sdio_pin_pkg::MODE_SPI)
        else $error("SPI not chosen at first reset command");
    a_sleep_measure: assert property (
        (sleep_tick && st_q.sleep_seen) |=> ref_count_valid
        && ref_per_sleep == $past(st_q.sleep_cnt))
        else $error("reference count not captured");
    a_cis_read: assert property (
        (!cis_wr_en) ##1 (cis_rd_addr == $past(cis_rd_addr) && !cis_wr_en)
        |=> cis_rd_data == $past(st_q.cis[cis_rd_addr]))
        else $error("card information read wrong");

    c_spi_entry: cover property (
        !st_q.cmd0_seen ##1 st_q.mode == sdio_pin_pkg::MODE_SPI);
    c_four_line: cover property (st_q.mode == sdio_pin_pkg::MODE_SD4 && irq_pending);
    c_boot: cover property (boot_start);
    c_sleep_valid: cover property ($rose(ref_count_valid));
endmodule
`default_nettype wire

//--- sdio_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module sdio_host_model (
    output logic card_clock_pad,
    output logic cmd_o,
    output logic cmd_oe,
    output logic dat3_o,
    output logic dat3_oe
);
    initial begin
        card_clock_pad = 1'b0;
        cmd_o = 1'b1;
        cmd_oe = 1'b0;
        dat3_o = 1'b1;
        dat3_oe = 1'b0;
    end
    task automatic set_cs(input logic cs_n);
        dat3_oe = !cs_n;
        dat3_o = cs_n;
    endtask
    task automatic send_frame(input logic [47:0] f, input logic cs_n);
        set_cs(cs_n);
        cmd_oe = 1'b1;
        for (int i = 47; i >= -2; i--) begin
            cmd_o = (i >= 0) ? f[i] : 1'b1;
            #63 card_clock_pad = 1'b1;
            #62 card_clock_pad = 1'b0;
        end
        cmd_oe = 1'b0;
        cmd_o = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- sdio_pin_mode_and_reset_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sdio_pin_mode_and_reset_tb;
    logic ref_clk, arst_n, card_clock_pad, power_down_reset_pin, external_reset_pin;
    logic sleep_clock_pin, soft_reset, core_cmd_o, core_cmd_oe, read_wait_req;
    logic width_set, width_four, fw_irq_set, host_irq_clr, cis_wr_en, host_cmd_bit;
    logic card_clk_rise, core_rst_n, boot_start, irq_pending, ref_count_valid, sleep_tick;
    logic cmd_i, cmd_o, cmd_oe_n, h_cmd, h_cmd_oe, h_cs, h_cs_oe;
    logic [3:0] core_dat_o, core_dat_oe, host_dat_bits, dat_i, dat_o, dat_oe_n;
    logic [sdio_pin_pkg::CIS_AW-1:0] cis_wr_addr, cis_rd_addr;
    logic [7:0] cis_wr_data, cis_rd_data;
    logic [7:0] cis_mem [sdio_pin_pkg::CIS_DEPTH];
    logic [1:0] bus_mode;
    logic [sdio_pin_pkg::CNT_W-1:0] ref_per_sleep;
    int seed = 32'hd198;
    int bad_count = 0;
    int total_checks = 0;
    int rises = 0;
    int ticks = 0;

    // pull-ups hold every released line high
    assign cmd_i = !cmd_oe_n ? cmd_o : (h_cmd_oe ? h_cmd : 1'b1);
    assign dat_i = (~dat_oe_n & dat_o) | (dat_oe_n & {!h_cs_oe | h_cs, 3'h7});

    sdio_pin_mode_and_reset DUT (
        .ref_clk, .arst_n, .card_clock_pad, .card_command_pad_i(cmd_i),
        .card_command_pad_o(cmd_o), .card_command_pad_oe_n(cmd_oe_n),
        .card_data0_pad_i(dat_i[0]), .card_data0_pad_o(dat_o[0]),
        .card_data0_pad_oe_n(dat_oe_n[0]), .card_data1_pad_i(dat_i[1]),
        .card_data1_pad_o(dat_o[1]), .card_data1_pad_oe_n(dat_oe_n[1]),
        .card_data2_pad_i(dat_i[2]), .card_data2_pad_o(dat_o[2]),
        .card_data2_pad_oe_n(dat_oe_n[2]), .card_data3_pad_i(dat_i[3]),
        .card_data3_pad_o(dat_o[3]), .card_data3_pad_oe_n(dat_oe_n[3]),
        .power_down_reset_pin, .external_reset_pin, .sleep_clock_pin, .soft_reset,
        .core_cmd_o, .core_cmd_oe, .core_dat_o, .core_dat_oe, .read_wait_req, .width_set,
        .width_four, .fw_irq_set, .host_irq_clr, .cis_wr_en, .cis_wr_addr, .cis_wr_data,
        .cis_rd_addr, .cis_rd_data, .host_cmd_bit, .host_dat_bits, .card_clk_rise,
        .bus_mode, .core_rst_n, .boot_start, .irq_pending, .ref_per_sleep,
        .ref_count_valid, .sleep_tick
    );
    sdio_host_model host (
        .card_clock_pad, .cmd_o(h_cmd), .cmd_oe(h_cmd_oe), .dat3_o(h_cs), .dat3_oe(h_cs_oe)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        sleep_clock_pin = 1'b0;
        forever #15260 sleep_clock_pin = ~sleep_clock_pin;
    end
    always @(posedge ref_clk) begin
        if (card_clk_rise === 1'b1) begin
            rises++;
        end
        if (sleep_tick === 1'b1) begin
            ticks++;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic boot_wait();
        int k;
        k = 0;
        while (boot_start !== 1'b1 && k < 20) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        chk(boot_start, 1'b1);
        chk(core_rst_n, 1'b1);
        @(negedge ref_clk);
    endtask

    // expected {enables, values} for command and data3..0, command on top
    function automatic logic [9:0] exp_pads(input logic [1:0] m, input logic irq, rw, cs,
            input logic co, coe, input logic [3:0] d, oe);
        logic [4:0] en, v;
        en = {coe && m != sdio_pin_pkg::MODE_SPI, 4'h0};
        v = {co, d};
        if (m == sdio_pin_pkg::MODE_SD4) begin
            en[3:0] = oe;
        end else begin
            en[0] = oe[0] && (m == sdio_pin_pkg::MODE_SD1 || !cs);
        end
        if (irq && !en[1]) begin
            en[1] = 1'b1;
            v[1] = 1'b0;
        end
        if (rw && !en[2] && m != sdio_pin_pkg::MODE_SPI) begin
            en[2] = 1'b1;
            v[2] = 1'b0;
        end
        return {en, v};
    endfunction

    task automatic vectors(input logic [1:0] m);
        logic [9:0] e;
        logic [4:0] en_n, lvl;
        logic [31:0] r;
        logic cs;
        repeat (8) begin
            r = $random(seed);
            {fw_irq_set, read_wait_req, core_cmd_o, core_cmd_oe} = r[3:0];
            {core_dat_o, core_dat_oe} = r[11:4];
            host_irq_clr = !fw_irq_set;
            if (m == sdio_pin_pkg::MODE_SPI) begin
                host.set_cs(r[12]);
            end
            // select settles, then data0 drive passes the pad synchroniser
            cyc(10);
            cs = !h_cs_oe | h_cs;
            e = exp_pads(m, fw_irq_set, read_wait_req, cs, core_cmd_o, core_cmd_oe,
                core_dat_o, core_dat_oe);
            en_n = ~e[9:5];
            lvl = (e[9:5] & e[4:0]) | (en_n & {1'b1, cs, 3'h7});
            chk(bus_mode, m);
            chk(irq_pending, fw_irq_set);
            chk({cmd_oe_n, dat_oe_n}, en_n);
            chk({cmd_o, dat_o} & e[9:5], e[4:0] & e[9:5]);
            chk({host_cmd_bit, host_dat_bits}, lvl);
        end
        {fw_irq_set, host_irq_clr, core_cmd_oe, core_dat_oe, read_wait_req} = 8'h40;
        cyc(2);
        host_irq_clr = 1'b0;
    endtask

    task automatic set_width(input logic four);
        width_four = four;
        width_set = 1'b1;
        cyc(1);
        width_set = 1'b0;
    endtask

    task automatic frame(input logic cs_n, input logic [1:0] m);
        rises = 0;
        host.send_frame({sdio_pin_pkg::CMD0_HEAD, 32'h0000_0000, 8'h95}, cs_n);
        cyc(6);
        chk(16'(rises), 16'h0032);
        chk(bus_mode, m);
        chk(host_cmd_bit, 1'b1);
    endtask

    task automatic cis_check();
        for (int i = 0; i < sdio_pin_pkg::CIS_DEPTH; i++) begin
            cis_rd_addr = sdio_pin_pkg::CIS_AW'(i);
            cyc(1);
            chk(cis_rd_data, cis_mem[i]);
        end
    endtask

    initial begin
        #400000;
        bad_count++;
        results();
    end

    initial begin
        {arst_n, power_down_reset_pin, external_reset_pin, soft_reset} = 4'h0;
        {core_cmd_o, core_cmd_oe, read_wait_req, width_set, width_four} = 5'h00;
        {fw_irq_set, host_irq_clr, cis_wr_en, cis_wr_data} = 11'h000;
        {core_dat_o, core_dat_oe, cis_wr_addr, cis_rd_addr} = 16'h0000;
        cyc(12);
        chk({cmd_oe_n, dat_oe_n, bus_mode, core_rst_n, irq_pending}, 16'h01f0);
        arst_n = 1'b1;
        cyc(10);
        chk(core_rst_n, 1'b0);
        {power_down_reset_pin, external_reset_pin} = 2'h3;
        boot_wait();
        for (int i = 0; i < sdio_pin_pkg::CIS_DEPTH; i++) begin
            cis_mem[i] = 8'($random(seed));
            cis_wr_en = 1'b1;
            cis_wr_addr = sdio_pin_pkg::CIS_AW'(i);
            cis_wr_data = cis_mem[i];
            cyc(1);
        end
        cis_wr_en = 1'b0;
        cis_check();
        vectors(sdio_pin_pkg::MODE_SD1);
        set_width(1'b1);
        chk(bus_mode, sdio_pin_pkg::MODE_SD4);
        vectors(sdio_pin_pkg::MODE_SD4);
        frame(1'b1, sdio_pin_pkg::MODE_SD1);
        frame(1'b0, sdio_pin_pkg::MODE_SD1);
        // only the first reset command after a reset may pick SPI
        soft_reset = 1'b1;
        cyc(1);
        soft_reset = 1'b0;
        cyc(4);
        frame(1'b0, sdio_pin_pkg::MODE_SPI);
        vectors(sdio_pin_pkg::MODE_SPI);
        set_width(1'b1);
        chk(bus_mode, sdio_pin_pkg::MODE_SPI);
        host.set_cs(1'b1);
        fw_irq_set = 1'b1;
        cyc(1);
        {fw_irq_set, soft_reset} = 2'h1;
        cyc(1);
        soft_reset = 1'b0;
        cyc(2);
        chk(bus_mode, sdio_pin_pkg::MODE_SD1);
        chk(irq_pending, 1'b0);
        cis_check();
        for (int p = 0; p < 2; p++) begin
            fw_irq_set = 1'b1;
            cyc(1);
            fw_irq_set = 1'b0;
            if (p == 0) begin
                power_down_reset_pin = 1'b0;
            end else begin
                external_reset_pin = 1'b0;
            end
            cyc(6);
            chk(core_rst_n, 1'b0);
            chk(irq_pending, 1'b0);
            {power_down_reset_pin, external_reset_pin} = 2'h3;
            boot_wait();
        end
        ticks = 0;
        cyc(6104);
        chk(16'(ticks), 16'h0002);
        chk(ref_count_valid, 1'b1);
        chk(ref_per_sleep, 16'h0bec);
        results();
    end
endmodule
`default_nettype wire
